// File: rtl/oosc_top.v
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "oosc_regs.vh"
//
// Behaviour
// - Oscillator runs 44 kHz, or 130 kHz variant
// - Cycle pulse plus 67% max-duty window
// - Skipping doubles rate except high-frequency variant
// - Sample feedback at cycle start; high turns on
// - Ignore feedback mid-cycle; finish begun cycles
// - Regulator charges supply only while switch off
// - Supply below 5.1 V forces switch off
// - Stay blocked until supply back at 5.8 V
// - Above 135 C disable switch and hold off
// - Re-enable once temperature fell 70 C
// - Current limit or window end ends on-time
// - Blank current limit briefly after turn-on
module oosc_top
(
   aclk,
   aresetn,
   feedback_gate,
   supply_below_low,
   supply_at_high,
   temp_over,
   temp_cooled,
   current_over,
   switch_on,
   regulator_charge,
   max_duty_window,
   cycle_clock,
   irq,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready
);
   input wire aclk;
   input wire aresetn;
   input wire feedback_gate; // Feedback-gate sense, high asks for energy
   input wire supply_below_low; // Supply node under 5.1 V
   input wire supply_at_high; // Supply node reached 5.8 V
   input wire temp_over; // Junction above 135 C
   input wire temp_cooled; // Junction fell 70 C below trip
   input wire current_over; // Switch current above current_threshold
   output reg switch_on; // Power switch gate
   output reg regulator_charge; // Supply regulator draws from drain
   output wire max_duty_window; // Oscillator max-duty window
   output wire cycle_clock; // Cycle-start pulse
   output wire irq; // Level interrupt
   input wire [4:0] s_axi_awaddr;
   input wire s_axi_awvalid;
   output wire s_axi_awready;
   input wire [31:0] s_axi_wdata;
   input wire [3:0] s_axi_wstrb;
   input wire s_axi_wvalid;
   output wire s_axi_wready;
   output reg [1:0] s_axi_bresp;
   output reg s_axi_bvalid;
   input wire s_axi_bready;
   input wire [4:0] s_axi_araddr;
   input wire s_axi_arvalid;
   output wire s_axi_arready;
   output reg [31:0] s_axi_rdata;
   output reg [1:0] s_axi_rresp;
   output reg s_axi_rvalid;
   input wire s_axi_rready;

   // Cycle counts derived from the rates
   localparam [31:0] PER_NOM_W = `OOSC_CLK_HZ / `OOSC_NOM_HZ;
   localparam [31:0] PER_DBL_W = `OOSC_CLK_HZ / (2 * `OOSC_NOM_HZ);
   localparam [31:0] PER_HF_W = `OOSC_CLK_HZ / `OOSC_HF_HZ;
   localparam [31:0] WIN_NOM_W = PER_NOM_W * `OOSC_DUTY_PCT / `OOSC_PCT_FULL;
   localparam [31:0] WIN_DBL_W = PER_DBL_W * `OOSC_DUTY_PCT / `OOSC_PCT_FULL;
   localparam [31:0] WIN_HF_W = PER_HF_W * `OOSC_DUTY_PCT / `OOSC_PCT_FULL;
   // Least time, so round up to whole clocks
   localparam [31:0] BLANK_W =
      (`OOSC_BLANK_NS * (`OOSC_CLK_HZ / 1000000) + 999) / 1000;

   // Register indices
   localparam [2:0] IX_CTRL = 3'h0;
   localparam [2:0] IX_STAT = 3'h1;
   localparam [2:0] IX_ISTAT = 3'h2;
   localparam [2:0] IX_IMASK = 3'h3;
   localparam [2:0] IX_SKIP = 3'h4;
   localparam [2:0] IX_NONE = 3'h7;

   // Protection state machine codes
   localparam [1:0] ST_RUN = 2'h0;
   localparam [1:0] ST_UV = 2'h1;
   localparam [1:0] ST_OT = 2'h2;
   localparam [1:0] ST_BOTH = 2'h3;

   // Byte address to register index; shared by read and write decode
   function [2:0] oosc_idx;
      input [4:0] addr;
      begin
         case (addr)
            `OOSC_OFF_CTRL: oosc_idx = IX_CTRL;
            `OOSC_OFF_STAT: oosc_idx = IX_STAT;
            `OOSC_OFF_ISTAT: oosc_idx = IX_ISTAT;
            `OOSC_OFF_IMASK: oosc_idx = IX_IMASK;
            `OOSC_OFF_SKIP: oosc_idx = IX_SKIP;
            default: oosc_idx = IX_NONE;
         endcase
      end
   endfunction

   wire [5:0] sync_in; // Pin-domain inputs
   wire [5:0] sync_out;
   wire fb_s; // Synchronised feedback gate
   wire uv_low_s;
   wire uv_high_s;
   wire ot_hot_s;
   wire ot_cool_s;
   wire cl_s; // Synchronised current comparator
   wire cyc_start;
   wire [`OOSC_CW-1:0] period;
   wire [`OOSC_CW-1:0] window;
   wire blocked; // Any protection active
   wire fire; // This cycle switches
   wire [`OOSC_CW-1:0] blank_len;

   reg [1:0] prot_reg; // Protection state
   reg [1:0] prot_next;
   reg [1:0] ctrl_reg; // Run enable and high-frequency variant
   reg [`OOSC_EVW-1:0] istat_reg; // Sticky event bits
   reg [`OOSC_EVW-1:0] istat_next;
   reg [`OOSC_EVW-1:0] imask_reg;
   reg [`OOSC_EVW-1:0] ev; // One-cycle event pulses
   reg [`OOSC_SKW-1:0] skip_reg; // Consecutive skipped cycles
   reg [`OOSC_CW-1:0] blank_reg; // Blanking countdown
   reg [4:0] aw_addr_reg;
   reg aw_full_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg w_full_reg;
   reg rd_clr; // Read of interrupt status in progress
   reg [2:0] rd_ix;
   reg [2:0] wr_ix;

   assign blank_len = BLANK_W[`OOSC_CW-1:0];

   // All comparator and pin inputs cross into the clock domain here
   assign sync_in = {feedback_gate, supply_below_low, supply_at_high,
                     temp_over, temp_cooled, current_over};
   oosc_sync3 #(.W(6)) u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(sync_in),
      .dout(sync_out)
   );
   assign fb_s = sync_out[5];
   assign uv_low_s = sync_out[4];
   assign uv_high_s = sync_out[3];
   assign ot_hot_s = sync_out[2];
   assign ot_cool_s = sync_out[1];
   assign cl_s = sync_out[0];

   // Rate choice: doubled while skipping, never on the high-frequency variant
   assign period = ctrl_reg[`OOSC_CTRL_HF] ? PER_HF_W[`OOSC_CW-1:0] :
                   (skip_reg != {`OOSC_SKW{1'b0}}) ? PER_DBL_W[`OOSC_CW-1:0] :
                   PER_NOM_W[`OOSC_CW-1:0];
   assign window = ctrl_reg[`OOSC_CTRL_HF] ? WIN_HF_W[`OOSC_CW-1:0] :
                   (skip_reg != {`OOSC_SKW{1'b0}}) ? WIN_DBL_W[`OOSC_CW-1:0] :
                   WIN_NOM_W[`OOSC_CW-1:0];

   oosc_osc u_osc
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .period(period),
      .window(window),
      .cycle_start(cyc_start),
      .duty_window(max_duty_window)
   );
   assign cycle_clock = cyc_start;

   // Protection wins over any feedback sample
   assign blocked = (prot_reg != ST_RUN);
   assign fire = fb_s & ~blocked & ctrl_reg[`OOSC_CTRL_RUN];

   // Under-voltage and over-temperature, each with its own hysteresis
   always @*
   begin
      prot_next = prot_reg;
      case (prot_reg)
         ST_RUN:
         begin
            // Low supply and heat trip independently
            prot_next = {ot_hot_s, uv_low_s};
         end
         ST_UV:
         begin
            // Leave only once supply back at the upper threshold
            prot_next = {ot_hot_s, ~uv_high_s | uv_low_s};
         end
         ST_OT:
         begin
            // Hold off until cooled by the hysteresis amount
            prot_next = {~ot_cool_s | ot_hot_s, uv_low_s};
         end
         ST_BOTH:
         begin
            prot_next = {~ot_cool_s | ot_hot_s, ~uv_high_s | uv_low_s};
         end
         default:
         begin
            prot_next = ST_BOTH;
         end
      endcase
   end

   // Protection register; starts blocked until supply is proven good
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prot_reg <= ST_UV;
      end
      else
      begin
         prot_reg <= prot_next;
      end
   end

   // Switch gate, blanking and skip counter
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         switch_on <= 1'b0;
         regulator_charge <= 1'b0;
         blank_reg <= {`OOSC_CW{1'b0}};
         skip_reg <= {`OOSC_SKW{1'b0}};
      end
      else
      begin
         // Charge only while the switch is off and will stay off
         regulator_charge <= ~switch_on & ~(cyc_start & fire);
         if (prot_next[0] | prot_next[1])
         begin
            // Protection forces the switch off at once
            switch_on <= 1'b0;
         end
         else if (cyc_start)
         begin
            // Single sample per cycle; later changes do not matter
            switch_on <= fire;
            blank_reg <= blank_len;
            if (fire)
            begin
               skip_reg <= {`OOSC_SKW{1'b0}};
            end
            else if (skip_reg != {`OOSC_SKW{1'b1}})
            begin
               skip_reg <= skip_reg + 1'b1;
            end
         end
         else if (switch_on)
         begin
            if (blank_reg != {`OOSC_CW{1'b0}})
            begin
               // Comparator ignored during the turn-on spike
               blank_reg <= blank_reg - 1'b1;
            end
            else if (cl_s)
            begin
               switch_on <= 1'b0;
            end
            if (!max_duty_window)
            begin
               switch_on <= 1'b0;
            end
         end
      end
   end

   // Event pulses feeding the sticky status
   always @*
   begin
      ev = {`OOSC_EVW{1'b0}};
      ev[`OOSC_EV_UV] = ~prot_reg[0] & prot_next[0];
      ev[`OOSC_EV_OT] = ~prot_reg[1] & prot_next[1];
      ev[`OOSC_EV_CL] = switch_on & cl_s & ~cyc_start &
                        (blank_reg == {`OOSC_CW{1'b0}});
      ev[`OOSC_EV_SKIP] = cyc_start & ~fire;
   end

   // Read clears only what it returned; a new event in that cycle survives
   always @*
   begin
      istat_next = istat_reg;
      if (rd_clr)
      begin
         istat_next = {`OOSC_EVW{1'b0}};
      end
      istat_next = istat_next | ev;
   end

   assign irq = |(istat_reg & imask_reg);

   // Write channels are taken in any order and held until both arrive
   assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
   assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   always @*
   begin
      wr_ix = oosc_idx(aw_addr_reg);
      rd_ix = oosc_idx(s_axi_araddr);
      rd_clr = s_axi_arvalid & ~s_axi_rvalid & (rd_ix == IX_ISTAT);
   end

   // Register bus slave and software-visible registers
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 5'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OOSC_RESP_OK;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `OOSC_RESP_OK;
         s_axi_rdata <= 32'h00000000;
         ctrl_reg <= `OOSC_CTRL_RST;
         imask_reg <= {`OOSC_EVW{1'b0}};
         istat_reg <= {`OOSC_EVW{1'b0}};
      end
      else
      begin
         istat_reg <= istat_next;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_addr_reg <= s_axi_awaddr;
            aw_full_reg <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_full_reg <= 1'b1;
         end
         if (aw_full_reg & w_full_reg)
         begin
            // Both halves present: commit and answer
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_ix == IX_NONE) ? `OOSC_RESP_ERR : `OOSC_RESP_OK;
            if (w_strb_reg[0])
            begin
               if (wr_ix == IX_CTRL)
               begin
                  ctrl_reg <= w_data_reg[1:0];
               end
               if (wr_ix == IX_IMASK)
               begin
                  imask_reg <= w_data_reg[`OOSC_EVW-1:0];
               end
            end
         end
         else if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid & s_axi_arready)
         begin
            // Read data is registered; answer one cycle after address
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `OOSC_RESP_OK;
            case (rd_ix)
               IX_CTRL: s_axi_rdata <= {30'h00000000, ctrl_reg};
               IX_STAT: s_axi_rdata <= {26'h0000000, fb_s,
                  (skip_reg != {`OOSC_SKW{1'b0}}), max_duty_window,
                  switch_on, prot_reg};
               IX_ISTAT: s_axi_rdata <= {28'h0000000, istat_reg};
               IX_IMASK: s_axi_rdata <= {28'h0000000, imask_reg};
               IX_SKIP: s_axi_rdata <= {16'h0000, skip_reg};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `OOSC_RESP_ERR;
               end
            endcase
         end
         else if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// File: rtl/oosc_regs.vh
`ifndef OOSC_REGS_VH
`define OOSC_REGS_VH
// Clock and oscillator rates in Hz
`define OOSC_CLK_HZ 100000000
`define OOSC_NOM_HZ 44000
`define OOSC_HF_HZ 130000
// Maximum-duty window as a percentage of the cycle
`define OOSC_DUTY_PCT 67
`define OOSC_PCT_FULL 100
// Turn-on blanking interval in ns and ns per second
`define OOSC_BLANK_NS 200
`define OOSC_NS_PER_S 1000000000
// Counter widths
`define OOSC_CW 12
`define OOSC_SKW 16
// Register byte offsets
`define OOSC_OFF_CTRL 5'h00
`define OOSC_OFF_STAT 5'h04
`define OOSC_OFF_ISTAT 5'h08
`define OOSC_OFF_IMASK 5'h0C
`define OOSC_OFF_SKIP 5'h10
// Control fields
`define OOSC_CTRL_RUN 0
`define OOSC_CTRL_HF 1
`define OOSC_CTRL_RST 2'h1
// Event bit positions (status and mask share layout)
`define OOSC_EV_UV 0
`define OOSC_EV_OT 1
`define OOSC_EV_CL 2
`define OOSC_EV_SKIP 3
`define OOSC_EVW 4
// AXI responses
`define OOSC_RESP_OK 2'h0
`define OOSC_RESP_ERR 2'h2
`endif

// File: rtl/oosc_sync3.v
`timescale 1ns/10ps
// Three-flop pin synchroniser; output moves only when stages two and three agree
module oosc_sync3
#(
   parameter W = 1
)
(
   aclk,
   aresetn,
   din,
   dout
);
   input wire aclk;
   input wire aresetn;
   input wire [W-1:0] din;
   output wire [W-1:0] dout;

   genvar gi;
   generate
      for (gi = 0; gi < W; gi = gi + 1)
      begin : g_bit
         reg s1_reg; // Only read by s2_reg
         reg s2_reg;
         reg s3_reg;
         reg q_reg; // Filtered value
         // Shift chain and agreement filter
         always @(posedge aclk)
         begin
            if (!aresetn)
            begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               q_reg <= 1'b0;
            end
            else
            begin
               s1_reg <= din[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg)
               begin
                  q_reg <= s3_reg;
               end
            end
         end
         assign dout[gi] = q_reg;
      end
   endgenerate
endmodule

// File: rtl/oosc_osc.v
`timescale 1ns/10ps
`include "oosc_regs.vh"
// Free-running cycle counter; period and window are taken only at wrap
module oosc_osc
(
   aclk,
   aresetn,
   period,
   window,
   cycle_start,
   duty_window
);
   input wire aclk;
   input wire aresetn;
   input wire [`OOSC_CW-1:0] period; // Cycle length in clocks
   input wire [`OOSC_CW-1:0] window; // Window length in clocks
   output reg cycle_start; // One-cycle pulse at cycle start
   output reg duty_window; // High in the max-duty part of the cycle

   reg [`OOSC_CW-1:0] cnt_reg;
   reg [`OOSC_CW-1:0] per_reg;
   reg [`OOSC_CW-1:0] win_reg;
   wire wrap;

   // Latching the rate only at wrap keeps every cycle whole
   assign wrap = (cnt_reg >= per_reg - 1'b1);

   // Counter, latched period and outputs
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_reg <= {`OOSC_CW{1'b0}};
         per_reg <= {`OOSC_CW{1'b1}};
         win_reg <= {`OOSC_CW{1'b0}};
         cycle_start <= 1'b0;
         duty_window <= 1'b0;
      end
      else
      begin
         cycle_start <= wrap;
         if (wrap)
         begin
            cnt_reg <= {`OOSC_CW{1'b0}};
            per_reg <= period;
            win_reg <= window;
            duty_window <= 1'b1;
         end
         else
         begin
            cnt_reg <= cnt_reg + 1'b1;
            duty_window <= (cnt_reg + 1'b1 < win_reg);
         end
      end
   end
endmodule

// File: tb/oosc_top_monitor.sv
`timescale 1ns/10ps
// Pin-level watcher for the switch controller
module oosc_top_monitor
(
   input wire aclk,
   input wire aresetn,
   input wire supply_below_low,
   input wire supply_at_high,
   input wire temp_over,
   input wire temp_cooled,
   input wire switch_on,
   input wire regulator_charge,
   input wire max_duty_window,
   input wire cycle_clock
);
   reg [12:0] gap_reg; // Clocks since the last cycle start
   reg [12:0] win_reg; // Clocks the window has been high
   reg seen_reg; // First cycle after reset has an odd length, so skip it
   // Helper counters for period and window length
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gap_reg <= 13'h0001;
         win_reg <= 13'h0000;
         seen_reg <= 1'b0;
      end
      else
      begin
         gap_reg <= cycle_clock ? 13'h0001 : gap_reg + 13'h0001;
         win_reg <= max_duty_window ? win_reg + 13'h0001 : 13'h0000;
         seen_reg <= seen_reg | cycle_clock;
      end
   end
   default clocking mc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Protection held long enough to pass the synchroniser and gate register
   sequence uv_s; supply_below_low [*6]; endsequence
   sequence ot_s; temp_over [*6]; endsequence
   a_cycle_pulse: assert property (cycle_clock |-> max_duty_window ##1 !cycle_clock)
      else $error("cycle pulse not single or outside window");
   a_turn_on_cause: assert property ($rose(switch_on) |-> $past(cycle_clock))
      else $error("switch turned on away from a cycle start");
   a_window_ends_on: assert property (switch_on |->
      max_duty_window || $past(max_duty_window))
      else $error("switch on outside the duty window");
   a_blank_hold: assert property ($rose(switch_on) |=> switch_on [*3])
      else $error("on-time cut inside blanking");
   a_charge_excl: assert property (regulator_charge |-> !switch_on)
      else $error("regulator charging while switch on");
   a_charge_after: assert property ($fell(switch_on) |-> ##[1:2] regulator_charge)
      else $error("regulator not charging after turn-off");
   a_uv_off: assert property (uv_s |-> !switch_on)
      else $error("switch on in under-voltage");
   a_ot_off: assert property (ot_s |-> !switch_on)
      else $error("switch on in over-temperature");
   a_uv_hold: assert property (uv_s ##1 (!supply_at_high) [*8] |-> !switch_on)
      else $error("switching resumed before supply recovered");
   a_ot_hold: assert property (ot_s ##1 (!temp_cooled) [*8] |-> !switch_on)
      else $error("switching resumed before cooling");
   a_period_len: assert property (cycle_clock && seen_reg |->
      gap_reg == 13'd2272 || gap_reg == 13'd1136 || gap_reg == 13'd769)
      else $error("cycle period not a legal rate");
   a_window_len: assert property ($fell(max_duty_window) && seen_reg |->
      win_reg == 13'd1522 || win_reg == 13'd761 || win_reg == 13'd515)
      else $error("duty window length wrong");
endmodule
bind oosc_top oosc_top_monitor mon (.aclk(aclk), .aresetn(aresetn),
   .supply_below_low(supply_below_low), .supply_at_high(supply_at_high),
   .temp_over(temp_over), .temp_cooled(temp_cooled), .switch_on(switch_on),
   .regulator_charge(regulator_charge), .max_duty_window(max_duty_window),
   .cycle_clock(cycle_clock));

// File: tb/oosc_plant_model.sv
`timescale 1ns/10ps
// Optocoupler feedback and transformer primary seen from the switch
module oosc_plant_model
(
   input wire aclk,
   input wire switch_on,
   input wire load_demand, // Secondary output below its target
   input wire [11:0] ramp_len, // Clocks to reach the current threshold, zero never
   output reg feedback_gate = 1'b0,
   output reg current_over
);
   reg [11:0] on_cnt = 12'h000; // Clocks the switch has conducted
   // Opto pulls the pin low to stop, leaves it high for more energy
   always @(posedge aclk)
      feedback_gate <= load_demand;
   // Primary current ramps only while the switch conducts
   always @(posedge aclk)
      on_cnt <= switch_on ? on_cnt + 12'h001 : 12'h000;
   // Comparator level; no hysteresis, like a real sense resistor
   always @*
      current_over = (ramp_len != 12'h000) && (on_cnt >= ramp_len);
endmodule

// File: tb/oosc_top_test.sv
`timescale 1ns/10ps
`include "oosc_regs.vh"
// Self-checking bench for the on/off switch controller
module oosc_top_test;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg demand = 1'b1;
   reg [11:0] ramp = 12'h000;
   reg below = 1'b0, athigh = 1'b0, tover = 1'b0, tcool = 1'b0;
   reg [4:0] awaddr = 5'h00, araddr = 5'h00;
   reg [31:0] wdata = 32'h00000000;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire fb, cov, sw, chg, win, cyc, irq, awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   reg [31:0] rv; // Last read word
   reg [1:0] rsp; // Response code of the last bus transfer
   int n; // Last measured period
   int miscompares = 0;
   int num_checks = 0;
   int cyc_count = 0;
   oosc_top uut (.aclk(aclk), .aresetn(aresetn), .feedback_gate(fb),
      .supply_below_low(below), .supply_at_high(athigh), .temp_over(tover),
      .temp_cooled(tcool), .current_over(cov), .switch_on(sw), .regulator_charge(chg),
      .max_duty_window(win), .cycle_clock(cyc), .irq(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   oosc_plant_model plant (.aclk(aclk), .switch_on(sw), .load_demand(demand),
      .ramp_len(ramp), .feedback_gate(fb), .current_over(cov));
   // 100 MHz clock
   always #5 aclk = ~aclk;
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hang guard, about twice the expected run
   always @(posedge aclk)
   begin
      cyc_count <= cyc_count + 1;
      if (cyc_count == 90000)
      begin
         miscompares = miscompares + 1;
         give_verdict;
      end
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Ready and valid are sampled at the falling edge, so handshakes see pre-edge values
   task wr(input [4:0] a, input [31:0] d);
      reg pa, pw, ha, hw, hb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      hb = 1'b0;
      while (!hb)
      begin
         @(negedge aclk);
         ha = pa & awready;
         hw = pw & wready;
         hb = bvalid;
         rsp = bresp;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         pa = pa & !ha;
         pw = pw & !hw;
      end
      bready <= 1'b0;
   endtask
   task rd(input [4:0] a, output [31:0] d);
      reg pa, ha, hb;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      pa = 1'b1;
      hb = 1'b0;
      while (!hb)
      begin
         @(negedge aclk);
         ha = pa & arready;
         hb = rvalid;
         rsp = rresp;
         d = rdata;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         pa = pa & !ha;
      end
      rready <= 1'b0;
   endtask
   // Ends at the edge that samples the next cycle pulse; counts clocks since the last
   task next_start(output int c);
      c = 0;
      do
      begin
         @(negedge aclk);
         c = c + 1;
      end while (!cyc);
      @(posedge aclk);
   endtask
   task at(input int k);
      repeat (k) @(negedge aclk);
   endtask
   // Switching held off until the supply first reaches its upper level
   task t_startup;
      next_start(n);
      at(3);
      check("sw before supply up", sw, 0);
      @(posedge aclk) athigh <= 1'b1;
      next_start(n);
      next_start(n);
      at(2);
      check("sw on demand", sw, 1);
      check("charge while on", chg, 0);
   endtask
   // Without a current limit the window alone ends the pulse
   task t_window;
      next_start(n);
      at(1500);
      check("sw late in window", sw, 1);
      at(30);
      check("sw after window", sw, 0);
      at(3);
      check("charge after off", chg, 1);
   endtask
   // Early current trip is blanked, later one ends the pulse and interrupts
   task t_climit;
      wr(`OOSC_OFF_IMASK, 32'h00000004);
      ramp <= 12'h005;
      next_start(n);
      next_start(n);
      at(15);
      check("sw in blanking", sw, 1);
      at(15);
      check("sw after trip", sw, 0);
      check("irq on trip", irq, 1);
      @(posedge aclk) ramp <= 12'h000;
      rd(`OOSC_OFF_ISTAT, rv);
      check("trip event", rv[2], 1);
      at(1);
      check("irq cleared", irq, 0);
   endtask
   // Skipped cycles double the rate, the fast variant keeps its own
   task t_skip;
      demand <= 1'b0;
      next_start(n);
      next_start(n);
      next_start(n);
      at(2);
      check("sw skipped", sw, 0);
      next_start(n);
      next_start(n);
      check("skip period", n, 1136);
      rd(`OOSC_OFF_STAT, rv);
      check("skipping flag", rv[4], 1);
      check("stat read resp", rsp, 0);
      wr(`OOSC_OFF_CTRL, 32'h00000003);
      check("ctrl write resp", rsp, 0);
      next_start(n);
      next_start(n);
      next_start(n);
      check("fast period", n, 769);
      wr(`OOSC_OFF_CTRL, 32'h00000001);
      next_start(n);
      next_start(n);
      demand <= 1'b1;
      at(500);
      check("late demand ignored", sw, 0);
      next_start(n);
      at(2);
      check("sw next cycle", sw, 1);
      next_start(n);
      next_start(n);
      check("nominal period", n, 2272);
   endtask
   // Thermal and supply trips with their hysteresis
   task t_protect;
      wr(`OOSC_OFF_IMASK, 32'h00000002);
      next_start(n);
      at(100);
      @(posedge aclk) tover <= 1'b1;
      at(7);
      check("sw hot", sw, 0);
      check("irq hot", irq, 1);
      @(posedge aclk) tover <= 1'b0;
      next_start(n);
      at(3);
      check("sw not cooled", sw, 0);
      @(posedge aclk) tcool <= 1'b1;
      next_start(n);
      at(3);
      check("sw cooled", sw, 1);
      @(posedge aclk) tcool <= 1'b0;
      at(100);
      @(posedge aclk) below <= 1'b1;
      athigh <= 1'b0;
      at(7);
      check("sw low supply", sw, 0);
      @(posedge aclk) below <= 1'b0;
      next_start(n);
      at(3);
      check("sw supply between", sw, 0);
      @(posedge aclk) athigh <= 1'b1;
      next_start(n);
      next_start(n);
      at(3);
      check("sw supply back", sw, 1);
      // Run bit cleared: every cycle is skipped and counted
      wr(`OOSC_OFF_CTRL, 32'h00000000);
      next_start(n);
      next_start(n);
      at(3);
      check("sw run off", sw, 0);
      rd(`OOSC_OFF_SKIP, rv);
      check("skip count", rv != 0, 1);
   endtask
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_startup;
      t_window;
      t_climit;
      t_skip;
      t_protect;
      give_verdict;
   end
endmodule
